// file: rtl/ssr_pkg.sv
// status reporting hierarchy constants: scpi register parts, status byte
// assumes one instrument clock; command decoding lives outside this block
// Operation
// R1 - five 16-bit parts, bits independent
// R2 - bit 15 of every part reads zero
// R3 - condition follows hardware, read-only, unchanged
// R4 - rising condition sets event if ptr
// R5 - falling condition sets event if ntr
// R6 - ptr, ntr, enable freely read/write
// R7 - event latches, read returns then clears
// R8 - sum bit is OR of event&enable
// R9 - sum bit feeds higher condition continuously
// R10 - status bit 6 is master summary
// R11 - mask bit 6 has no effect
// R12 - enabled status bit rising raises request
// R13 - status byte read by query or poll
// R14 - mask written by set, read by query
// R15 - status bit 2: error queue not empty
// R16 - status bit 3: questionable sum bit
// R17 - status bit 4: message available
// R18 - status bit 5: standard event sum
// R19 - status bit 7: operation sum bit
// R20 - controller should enable error-queue bit
// R21 - transition during clear-on-read survives
package ssr_pkg;
   localparam int unsigned PART_W = 16;
   localparam int unsigned STB_W = 8;
   // scpi register selectors
   localparam logic [0:0] REG_OPER = 1'h0;
   localparam logic [0:0] REG_QUES = 1'h1;
   // part selectors
   localparam logic [2:0] PART_COND = 3'h0;
   localparam logic [2:0] PART_PTR = 3'h1;
   localparam logic [2:0] PART_NTR = 3'h2;
   localparam logic [2:0] PART_EVENT = 3'h3;
   localparam logic [2:0] PART_ENAB = 3'h4;
   // status byte bit positions
   localparam int unsigned STB_ERRQ = 2;
   localparam int unsigned STB_QUES = 3;
   localparam int unsigned STB_MAV = 4;
   localparam int unsigned STB_ESB = 5;
   localparam int unsigned STB_MSS = 6;
   localparam int unsigned STB_OPER = 7;
   // reset values
   localparam logic [15:0] PTR_RST = 16'h7fff;
   localparam logic [15:0] NTR_RST = 16'h0000;
   localparam logic [15:0] ENAB_RST = 16'h0000;
   localparam logic [7:0] SRQ_MASK_RST = 8'h00;
   localparam logic [15:0] PART_VALID = 16'h7fff;
   localparam logic [7:0] SRQ_MASK_VALID = 8'hbf;
   typedef enum logic [1:0] {
      SSR_IDLE = 2'b01,
      SSR_REQ = 2'b10
   } ssr_srq_state_t;
endpackage

// file: rtl/ssr_scpi_reg.sv
// one scpi status register: condition, filters, event, enable, sum bit
// assumes condition bits synchronous to sys_clk_i
`timescale 1ns/100ps
module ssr_scpi_reg #(
   parameter int unsigned W = 16
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // condition source
   input wire logic [W-1:0] cond_i,
   // access strobes
   input wire logic ptr_wr_i,
   input wire logic ntr_wr_i,
   input wire logic enab_wr_i,
   input wire logic event_rd_i,
   input wire logic [W-1:0] wdata_i,
   // part contents
   output logic [W-1:0] cond_o,
   output logic [W-1:0] ptr_o,
   output logic [W-1:0] ntr_o,
   output logic [W-1:0] event_o,
   output logic [W-1:0] enab_o,
   output logic sum_o
);
   import ssr_pkg::*;

   initial begin
      if (W != PART_W) $error("ssr_scpi_reg: W must be 16");
   end

   logic [W-1:0] cond_q, ptr_q, ntr_q, event_q, enab_q, event_d;
   logic [W-1:0] rise, fall;

   // msb forced to zero in every part
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cond_q <= '0;
      end else begin
         cond_q <= cond_i & PART_VALID; // see R1, see R2, see R3
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ptr_q <= PTR_RST;
         ntr_q <= NTR_RST;
         enab_q <= ENAB_RST;
      end else begin
         if (ptr_wr_i) ptr_q <= wdata_i & PART_VALID; // see R6
         if (ntr_wr_i) ntr_q <= wdata_i & PART_VALID; // see R6
         if (enab_wr_i) enab_q <= wdata_i & PART_VALID; // see R6
      end
   end

   assign rise = (cond_i & PART_VALID) & ~cond_q & ptr_q; // see R4
   assign fall = ~(cond_i & PART_VALID) & cond_q & ntr_q; // see R5

   // new transitions win over the clear so none is lost
   always_comb begin
      event_d = event_rd_i ? '0 : event_q; // see R7
      event_d = event_d | rise | fall; // see R21
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         event_q <= '0;
      end else begin
         event_q <= event_d & PART_VALID;
      end
   end

   assign cond_o = cond_q;
   assign ptr_o = ptr_q;
   assign ntr_o = ntr_q;
   assign event_o = event_q;
   assign enab_o = enab_q;
   assign sum_o = |(event_q & enab_q); // see R8, see R9
endmodule // ssr_scpi_reg

// file: rtl/ssr_top.sv
// status reporting top: operation and questionable registers, status byte,
// service-request mask, request and read-back port
// assumes command decoder drives one-cycle strobes synchronous to sys_clk_i
`timescale 1ns/100ps
module ssr_top (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // hardware status sources
   input wire logic [ssr_pkg::PART_W-1:0] oper_cond_i,
   input wire logic [ssr_pkg::PART_W-1:0] ques_cond_i,
   input wire logic err_queue_not_empty_i,
   input wire logic msg_avail_i,
   input wire logic std_event_sum_i,
   // scpi register access
   input wire logic reg_sel_i,
   input wire logic [2:0] part_sel_i,
   input wire logic part_wr_i,
   input wire logic part_rd_i,
   input wire logic [ssr_pkg::PART_W-1:0] part_wdata_i,
   output logic [ssr_pkg::PART_W-1:0] part_rdata_o,
   // status byte and mask commands
   input wire logic stb_rd_i,
   input wire logic serial_poll_i,
   input wire logic srq_mask_wr_i,
   input wire logic srq_mask_rd_i,
   input wire logic [ssr_pkg::STB_W-1:0] srq_mask_wdata_i,
   output logic [ssr_pkg::STB_W-1:0] stb_rdata_o,
   // bus service request
   output logic srq_o,
   output logic [ssr_pkg::STB_W-1:0] status_byte_o
);
   import ssr_pkg::*;

   logic oper_hit, ques_hit;
   logic [PART_W-1:0] op_cond, op_ptr, op_ntr, op_evt, op_enab;
   logic [PART_W-1:0] qu_cond, qu_ptr, qu_ntr, qu_evt, qu_enab;
   logic oper_sum, ques_sum;
   logic [STB_W-1:0] stb, stb_prev_q, srq_mask_q, rdata_d;
   logic [STB_W-1:0] stb_rdata_q;
   logic [PART_W-1:0] part_rdata_q, part_d;
   logic mss, srq_rise;
   ssr_srq_state_t srq_state_q;

   function automatic logic [PART_W-1:0] pick_part(
      input logic [2:0] sel,
      input logic [PART_W-1:0] c, p, n, e, en);
      case (sel)
         PART_COND: pick_part = c;
         PART_PTR: pick_part = p;
         PART_NTR: pick_part = n;
         PART_EVENT: pick_part = e;
         PART_ENAB: pick_part = en;
         default: pick_part = '0;
      endcase
   endfunction

   assign oper_hit = (reg_sel_i == REG_OPER);
   assign ques_hit = (reg_sel_i == REG_QUES);

   ssr_scpi_reg #(.W(PART_W)) u_oper (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .cond_i(oper_cond_i),
      .ptr_wr_i(part_wr_i && oper_hit && part_sel_i == PART_PTR),
      .ntr_wr_i(part_wr_i && oper_hit && part_sel_i == PART_NTR),
      .enab_wr_i(part_wr_i && oper_hit && part_sel_i == PART_ENAB),
      .event_rd_i(part_rd_i && oper_hit && part_sel_i == PART_EVENT),
      .wdata_i(part_wdata_i),
      .cond_o(op_cond),
      .ptr_o(op_ptr),
      .ntr_o(op_ntr),
      .event_o(op_evt),
      .enab_o(op_enab),
      .sum_o(oper_sum)
   );

   ssr_scpi_reg #(.W(PART_W)) u_ques (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .cond_i(ques_cond_i),
      .ptr_wr_i(part_wr_i && ques_hit && part_sel_i == PART_PTR),
      .ntr_wr_i(part_wr_i && ques_hit && part_sel_i == PART_NTR),
      .enab_wr_i(part_wr_i && ques_hit && part_sel_i == PART_ENAB),
      .event_rd_i(part_rd_i && ques_hit && part_sel_i == PART_EVENT),
      .wdata_i(part_wdata_i),
      .cond_o(qu_cond),
      .ptr_o(qu_ptr),
      .ntr_o(qu_ntr),
      .event_o(qu_evt),
      .enab_o(qu_enab),
      .sum_o(ques_sum)
   );

   // read data captured in the same cycle the event part clears
   always_comb begin
      part_d = oper_hit ?
         pick_part(part_sel_i, op_cond, op_ptr, op_ntr, op_evt, op_enab) :
         pick_part(part_sel_i, qu_cond, qu_ptr, qu_ntr, qu_evt, qu_enab);
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         part_rdata_q <= '0;
      end else if (part_rd_i) begin
         part_rdata_q <= part_d & PART_VALID; // see R2, see R7
      end
   end

   // status byte assembled from sum bits and level sources
   always_comb begin
      stb = '0;
      stb[STB_ERRQ] = err_queue_not_empty_i; // see R15
      stb[STB_QUES] = ques_sum; // see R16, see R9
      stb[STB_MAV] = msg_avail_i; // see R17
      stb[STB_ESB] = std_event_sum_i; // see R18
      stb[STB_OPER] = oper_sum; // see R19, see R9
      // mask bit 6 dropped so mss cannot feed itself
      mss = |(stb & srq_mask_q & SRQ_MASK_VALID); // see R10, see R11
      stb[STB_MSS] = mss; // see R10
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         srq_mask_q <= SRQ_MASK_RST;
      end else if (srq_mask_wr_i) begin
         srq_mask_q <= srq_mask_wdata_i; // see R14
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stb_prev_q <= '0;
      end else begin
         stb_prev_q <= stb;
      end
   end

   assign srq_rise = |(stb & ~stb_prev_q & srq_mask_q & SRQ_MASK_VALID);

   // request held until the summary drops or a serial poll takes it;
   // a fresh rising edge during the poll keeps it asserted
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         srq_state_q <= SSR_IDLE;
      end else begin
         case (srq_state_q)
            SSR_IDLE: begin
               if (srq_rise) srq_state_q <= SSR_REQ; // see R12
            end
            SSR_REQ: begin
               if (srq_rise) srq_state_q <= SSR_REQ; // see R12
               else if (serial_poll_i || !mss) srq_state_q <= SSR_IDLE;
            end
            default: srq_state_q <= SSR_IDLE;
         endcase
      end
   end

   // mask query and status query share one answer register
   always_comb begin
      rdata_d = stb_rdata_q;
      if (srq_mask_rd_i) rdata_d = srq_mask_q; // see R14
      if (stb_rd_i || serial_poll_i) rdata_d = stb; // see R13
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stb_rdata_q <= '0;
      end else begin
         stb_rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_byte_o <= '0;
      end else begin
         status_byte_o <= stb;
      end
   end

   assign srq_o = (srq_state_q == SSR_REQ);
   assign stb_rdata_o = stb_rdata_q;
   assign part_rdata_o = part_rdata_q;
endmodule // ssr_top

// file: tb/ssr_checker.sv
// checker: part access, mask and status byte relations of ssr_top
// assumes bind onto ssr_top; mask tracked from its own write strobe
`timescale 1ns/100ps
module ssr_checker
   import ssr_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // sources
   input wire logic [15:0] oper_cond_i,
   input wire logic [15:0] ques_cond_i,
   input wire logic err_queue_not_empty_i,
   input wire logic msg_avail_i,
   input wire logic std_event_sum_i,
   // part access
   input wire logic reg_sel_i,
   input wire logic [2:0] part_sel_i,
   input wire logic part_wr_i,
   input wire logic part_rd_i,
   input wire logic [15:0] part_wdata_i,
   input wire logic [15:0] part_rdata_o,
   // status byte
   input wire logic stb_rd_i,
   input wire logic serial_poll_i,
   input wire logic srq_mask_wr_i,
   input wire logic srq_mask_rd_i,
   input wire logic [7:0] srq_mask_wdata_i,
   input wire logic [7:0] stb_rdata_o,
   input wire logic srq_o,
   input wire logic [7:0] status_byte_o
);
   logic [7:0] mask_q;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) mask_q <= 8'h00;
      else if (srq_mask_wr_i) mask_q <= srq_mask_wdata_i;
   end
   property p_msb;
      !part_rdata_o[15];
   endproperty
   a_msb: assert property (p_msb) else $error("msb set");
   property p_mss;
      status_byte_o[6] == |(status_byte_o & $past(mask_q) & 8'hbf);
   endproperty
   a_mss: assert property (p_mss) else $error("summary");
   property p_direct;
      $past(rst_n_i) |-> status_byte_o[2] == $past(err_queue_not_empty_i)
         && status_byte_o[5:4] == $past({std_event_sum_i, msg_avail_i});
   endproperty
   a_direct: assert property (p_direct)
      else $error("bits");
   property p_cond;
      part_rd_i && part_sel_i == PART_COND && reg_sel_i == REG_OPER
         && $stable(oper_cond_i) && $past(rst_n_i)
         |=> part_rdata_o == ($past(oper_cond_i) & PART_VALID);
   endproperty
   a_cond: assert property (p_cond) else $error("cond");
   property p_stb_ans;
      stb_rd_i || serial_poll_i |=> stb_rdata_o == status_byte_o;
   endproperty
   a_stb_ans: assert property (p_stb_ans) else $error("stb");
   property p_mask_rd;
      srq_mask_rd_i && !stb_rd_i && !serial_poll_i
         |=> stb_rdata_o == $past(mask_q);
   endproperty
   a_mask_rd: assert property (p_mask_rd) else $error("mask");
   property p_ev_clr;
      part_rd_i && part_sel_i == PART_EVENT && $stable(oper_cond_i)
         && $stable(ques_cond_i) ##1 !part_rd_i && $stable(oper_cond_i)
         && $stable(ques_cond_i) ##1 part_rd_i && part_sel_i == PART_EVENT
         && reg_sel_i == $past(reg_sel_i, 2) |=> part_rdata_o == 16'h0000;
   endproperty
   a_ev_clr: assert property (p_ev_clr) else $error("event");
   property p_wr_rd;
      part_wr_i && (part_sel_i == PART_PTR || part_sel_i == PART_NTR
         || part_sel_i == PART_ENAB) ##1 !part_wr_i ##1 part_rd_i
         && !part_wr_i && part_sel_i == $past(part_sel_i, 2)
         && reg_sel_i == $past(reg_sel_i, 2)
         |=> part_rdata_o == ($past(part_wdata_i, 3) & PART_VALID);
   endproperty
   a_wr_rd: assert property (p_wr_rd) else $error("rw part");
endmodule // ssr_checker

bind ssr_top ssr_checker u_ssr_checker (.*);

// file: tb/ssr_ctrl_model.sv
// controller model: answers a service request with a serial poll
// assumes it alone drives the poll strobe; delay sets how slow it is
`timescale 1ns/100ps
module ssr_ctrl_model (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // bus side
   input wire logic srq_i,
   input wire logic [7:0] stb_rdata_i,
   input wire logic [3:0] delay_i,
   output logic serial_poll_o = 1'b0,
   output logic [7:0] polled_o = 8'h00
);
   int wait_cnt = 0;
   // drives on the falling edge so one rising edge takes the strobe
   always @(negedge sys_clk_i) begin
      if (serial_poll_o) begin
         serial_poll_o <= 1'b0;
         polled_o <= stb_rdata_i;
         wait_cnt <= 0;
      end else if (srq_i && rst_n_i) begin
         if (wait_cnt >= delay_i) serial_poll_o <= 1'b1;
         else wait_cnt <= wait_cnt + 1;
      end
   end
endmodule // ssr_ctrl_model

// file: tb/ssr_top_bench.sv
// bench for ssr_top: part, mask and status accesses plus a polling
// controller; assumes strobes are driven on the falling edge
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
   $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module ssr_top_bench;
   import ssr_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [15:0] oper_cond_i = 16'h0000;
   logic [15:0] ques_cond_i = 16'h0000;
   logic err_i = 1'b0, msg_i = 1'b0, std_i = 1'b0, reg_sel = 1'b0;
   logic wr_stb = 1'b0, rd_stb = 1'b0, stb_rd = 1'b0, poll, srq;
   logic mask_wr = 1'b0, mask_rd = 1'b0;
   logic [2:0] part_sel = 3'h0;
   logic [3:0] dly = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata;
   logic [7:0] mask_wdata = 8'h00, stb_rdata, polled;
   int errors = 0, tests_run = 0;
   logic [15:0] rst_v [6] = '{16'h0, 16'h7fff, 16'h0, 16'h0, 16'h0, 16'h0};
   logic [15:0] wr_v [6] = '{16'h0, 16'h7fff, 16'h7fff, 16'h0, 16'h7fff,
      16'h0};
   always #20 sys_clk_i = ~sys_clk_i;
   ssr_top u_ssr_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .oper_cond_i(oper_cond_i), .ques_cond_i(ques_cond_i),
      .err_queue_not_empty_i(err_i), .msg_avail_i(msg_i),
      .std_event_sum_i(std_i), .reg_sel_i(reg_sel), .part_sel_i(part_sel),
      .part_wr_i(wr_stb), .part_rd_i(rd_stb), .part_wdata_i(wdata),
      .part_rdata_o(rdata), .stb_rd_i(stb_rd), .serial_poll_i(poll),
      .srq_mask_wr_i(mask_wr), .srq_mask_rd_i(mask_rd),
      .srq_mask_wdata_i(mask_wdata), .stb_rdata_o(stb_rdata),
      .srq_o(srq), .status_byte_o());
   ssr_ctrl_model u_ssr_ctrl_model (.sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i), .srq_i(srq), .stb_rdata_i(stb_rdata),
      .delay_i(dly), .serial_poll_o(poll), .polled_o(polled));
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // each access leaves one idle cycle behind it
   task automatic part(input logic w, input logic r, input logic [2:0] s,
         input logic [15:0] v);
      reg_sel = r;
      part_sel = s;
      wdata = v;
      wr_stb = w;
      rd_stb = !w;
      @(negedge sys_clk_i);
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      if (!w) `CHK(rdata, v)
      @(negedge sys_clk_i);
   endtask
   // c: 0 mask write, 1 mask query, 2 status query
   task automatic cmd(input int c, input logic [7:0] v);
      mask_wdata = v;
      mask_wr = (c == 0);
      mask_rd = (c == 1);
      stb_rd = (c == 2);
      @(negedge sys_clk_i);
      {mask_wr, mask_rd, stb_rd} = 3'h0;
      if (c != 0) `CHK(stb_rdata, v)
      @(negedge sys_clk_i);
   endtask
   task automatic wait_poll(input logic [7:0] v);
      int n;
      n = 0;
      while (srq !== 1'b1 && n < 60) begin
         @(negedge sys_clk_i);
         n++;
      end
      while (srq !== 1'b0 && n < 60) begin
         @(negedge sys_clk_i);
         n++;
      end
      if (n >= 60) begin
         errors++;
         summarize();
      end
      @(negedge sys_clk_i);
      `CHK(polled, v)
   endtask
   initial begin
      repeat (20) @(negedge sys_clk_i);
      rst_n_i = 1'b1;
      @(negedge sys_clk_i);
      for (int r = 0; r < 2; r++)
         for (int s = 0; s < 6; s++)
            part(0, r[0], s[2:0], rst_v[s]);
      cmd(1, 8'h00);
      for (int r = 0; r < 2; r++)
         for (int s = 0; s < 6; s++) begin
            part(1, r[0], s[2:0], 16'hffff);
            part(0, r[0], s[2:0], wr_v[s]);
         end
      $display("reset and part access done");
      part(1, 0, PART_PTR, 16'h0002);
      part(1, 0, PART_NTR, 16'h0004);
      part(1, 0, PART_ENAB, 16'h0000);
      oper_cond_i = 16'h0006;
      repeat (2) @(negedge sys_clk_i);
      part(0, 0, PART_EVENT, 16'h0002);
      part(0, 0, PART_COND, 16'h0006);
      oper_cond_i = 16'h0000;
      repeat (2) @(negedge sys_clk_i);
      part(0, 0, PART_EVENT, 16'h0004);
      part(0, 0, PART_EVENT, 16'h0000);
      oper_cond_i = 16'h0002;
      part(0, 0, PART_EVENT, 16'h0000);
      part(0, 0, PART_EVENT, 16'h0002);
      oper_cond_i = 16'h0000;
      $display("transitions done");
      cmd(0, 8'hc4);
      cmd(1, 8'hc4);
      part(1, 0, PART_ENAB, 16'h0002);
      oper_cond_i = 16'h0002;
      wait_poll(8'hc0);
      part(0, 0, PART_EVENT, 16'h0002);
      dly = 4'h9;
      err_i = 1'b1;
      wait_poll(8'h44);
      msg_i = 1'b1;
      std_i = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      cmd(2, 8'h74);
      err_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      cmd(2, 8'h30);
      part(1, 1, PART_ENAB, 16'h0008);
      cmd(0, 8'h08);
      ques_cond_i = 16'h0008;
      wait_poll(8'h78);
      $display("status byte done");
      summarize();
   end
endmodule // ssr_top_bench
